// >>> hdl/eip_bank.sv
// Overview of operation
// - Bit 7 puts the timer 3 interrupt at low level when 0 and high level when 1.
// - Bit 5 sets the level of the analog comparator interrupt, rising and falling causes alike.
// - Bit 4 sets the level of the counter array interrupt, 0 low and 1 high.
// - Bit 3 sets the level of the converter conversion-done interrupt, 0 low and 1 high.
// - Bit 2 sets the level of the converter window-compare interrupt, 0 low and 1 high.
// - Bit 1 sets the level of the pin match interrupt, 0 low and 1 high.
// - Bit 0 sets the level of the two-wire bus interrupt, 0 low and 1 high.
// - The register answers at address 0xCE only while page F is selected.
`timescale 1ns/1ps
`default_nettype none
`include "eip_regs.svh"

module eip_bank
  import eip_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       reset_n_i,
  // special function register bus from the core
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic [7:0] sfr_page_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  output logic            sfr_hit_o,
  // interrupt sources and their enables
  input  wire logic [7:0] src_flag_i,
  input  wire logic [7:0] src_enable_i,
  input  wire logic       global_enable_i,
  // handshake with the core interrupt sequencer
  input  wire logic       irq_ack_i,
  input  wire logic       irq_return_i,
  output logic            irq_req_o,
  output logic            irq_high_o,
  output logic      [2:0] irq_idx_o,
  // per source level selects and nesting state
  output logic      [7:0] level_select_o,
  output logic            low_active_o,
  output logic            high_active_o
);

  // register storage and bus decode
  eip_byte_t prio_ff;
  eip_byte_t rdata_ff;
  logic      hit;
  logic      wr_hit;
  logic      rd_hit;

  // named level selects, one per source
  logic timer3_level_select;
  logic comparator_level_select;
  logic counter_array_level_select;
  logic conv_done_level_select;
  logic window_compare_level_select;
  logic pin_match_level_select;
  logic twowire_level_select;

  // nesting state and offered request
  eip_nest_t nest_ff;
  eip_nest_t nxt_nest;
  logic      req_ff;
  logic      high_ff;
  eip_idx_t  idx_ff;
  logic      take;

  // bundle that carries candidates to the arbiter and its choice back
  eip_arb_if ai ();

  // the register only exists on page F; other pages see the address as foreign
  // the decode is combinational so a strobe is taken on the very edge it is sampled;
  // the core holds address and page steady for the whole strobe cycle, so no
  // glitch on hit can reach a flop
  assign hit    = (sfr_addr_i == `EIP_PRIO_ADDR) && (sfr_page_i == `EIP_PRIO_PAGE);
  assign wr_hit = sfr_wr_i && hit;
  assign rd_hit = sfr_rd_i && hit;
  assign sfr_hit_o = hit;

  // priority register; bit 6 is stored as written, software keeps it zero
  // storing the reserved bit costs one flop but keeps read-back honest if code
  // ever breaks the write-zero convention; the bit still drives no source
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      prio_ff <= `EIP_PRIO_RESET;
    end else if (wr_hit) begin
      prio_ff <= sfr_wdata_i;
    end
  end

  // read data is held until the next read; a foreign read returns zero
  // a read and a write in the same cycle return the old contents, since the
  // read flop samples the register before the write lands
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      rdata_ff <= `EIP_READ_IDLE;
    end else if (rd_hit) begin
      rdata_ff <= prio_ff;
    end else if (sfr_rd_i) begin
      rdata_ff <= `EIP_READ_IDLE;
    end
  end

  assign sfr_rdata_o = rdata_ff;

  // break the register out into its per source level selects
  // these named wires and the level rebuild below are the only places the bit positions are bound to sources
  assign timer3_level_select         = prio_ff[`EIP_BIT_TIMER3];
  assign comparator_level_select     = prio_ff[`EIP_BIT_COMPARATOR];
  assign counter_array_level_select  = prio_ff[`EIP_BIT_CNT_ARRAY];
  assign conv_done_level_select      = prio_ff[`EIP_BIT_CONV_DONE];
  assign window_compare_level_select = prio_ff[`EIP_BIT_WINDOW];
  assign pin_match_level_select      = prio_ff[`EIP_BIT_PIN_MATCH];
  assign twowire_level_select        = prio_ff[`EIP_BIT_TWOWIRE];

  // rebuild the level vector; the reserved slot never carries a source
  // forcing the reserved slot low means a stray one there can never make the
  // arbiter treat an empty slot as a high level candidate
  always_comb begin
    ai.lvl                      = `EIP_PRIO_RESET;
    ai.lvl[`EIP_BIT_TIMER3]     = timer3_level_select;
    ai.lvl[`EIP_BIT_COMPARATOR] = comparator_level_select;
    ai.lvl[`EIP_BIT_CNT_ARRAY]  = counter_array_level_select;
    ai.lvl[`EIP_BIT_CONV_DONE]  = conv_done_level_select;
    ai.lvl[`EIP_BIT_WINDOW]     = window_compare_level_select;
    ai.lvl[`EIP_BIT_PIN_MATCH]  = pin_match_level_select;
    ai.lvl[`EIP_BIT_TWOWIRE]    = twowire_level_select;
  end

  assign level_select_o = ai.lvl;

  // a source competes only while flagged, enabled and globally allowed
  // flags are owned by the sources and cleared by software; this block only
  // reads them, so a flag left set keeps competing after its handler returns
  assign ai.pend = global_enable_i ? (src_flag_i & src_enable_i & `EIP_LIVE_MASK) : `EIP_READ_IDLE;

  // high may enter unless a high handler runs; low only when nothing runs
  // a second high request waits for the running high handler to return, it
  // never nests on top of it
  assign ai.allow_high = (nest_ff == eip_st_idle) || (nest_ff == eip_st_low);
  assign ai.allow_low  = (nest_ff == eip_st_idle);

  // arbiter picks the winner among the live candidates
  eip_arbiter u_arbiter (
    .ai (ai)
  );

  // the choice is registered so the core sees stable index and level;
  // costs one cycle of latency after a flag rises
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      req_ff  <= 1'b0;
      high_ff <= 1'b0;
      idx_ff  <= `EIP_IDX_NONE;
    end else if (take) begin
      req_ff  <= 1'b0; // withdraw for one cycle so a stale choice is never taken twice
      high_ff <= 1'b0;
      idx_ff  <= `EIP_IDX_NONE;
    end else begin
      req_ff  <= ai.req;
      high_ff <= ai.high;
      idx_ff  <= ai.idx;
    end
  end

  // an ack only counts while an offer stands; a stray ack is ignored
  assign take       = irq_ack_i && req_ff;
  assign irq_req_o  = req_ff;
  assign irq_high_o = high_ff;
  assign irq_idx_o  = idx_ff;

  // nesting tracker: an ack enters a handler, a return leaves the innermost
  // only two levels exist, so the nest state is enough to remember that a low
  // handler sits underneath the running high one; a return from nest resumes it
  always_comb begin
    nxt_nest = nest_ff;
    case (nest_ff)
      eip_st_idle: begin
        if (take) begin
          nxt_nest = high_ff ? eip_st_high : eip_st_low;
        end
      end
      eip_st_low: begin
        if (take && high_ff) begin
          nxt_nest = eip_st_nest;
        end else if (irq_return_i) begin
          nxt_nest = eip_st_idle;
        end
      end
      eip_st_high: begin
        if (irq_return_i) begin
          nxt_nest = eip_st_idle;
        end
      end
      eip_st_nest: begin
        if (irq_return_i) begin // back to the preempted low handler
          nxt_nest = eip_st_low;
        end
      end
      default: begin
        nxt_nest = eip_st_idle;
      end
    endcase
  end

  // state register of the nesting tracker
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      nest_ff <= eip_st_idle;
    end else begin
      nest_ff <= nxt_nest;
    end
  end

  // nesting state seen by the core
  // low stays reported while preempted so the core knows a low handler is
  // still open underneath
  assign low_active_o  = (nest_ff == eip_st_low) || (nest_ff == eip_st_nest);
  assign high_active_o = (nest_ff == eip_st_high) || (nest_ff == eip_st_nest);

endmodule : eip_bank

`default_nettype wire

// >>> hdl/eip_regs.svh
`ifndef EIP_REGS_SVH
`define EIP_REGS_SVH

// register decode
`define EIP_PRIO_ADDR      8'hCE
`define EIP_PRIO_PAGE      8'h0F
`define EIP_PRIO_RESET     8'h00
`define EIP_READ_IDLE      8'h00

// bit positions inside the priority register
`define EIP_BIT_TWOWIRE    0
`define EIP_BIT_PIN_MATCH  1
`define EIP_BIT_WINDOW     2
`define EIP_BIT_CONV_DONE  3
`define EIP_BIT_CNT_ARRAY  4
`define EIP_BIT_COMPARATOR 5
`define EIP_BIT_RESERVED   6
`define EIP_BIT_TIMER3     7

// source vector shape
`define EIP_NSRC           8
`define EIP_IDX_W          3
`define EIP_IDX_NONE       3'h0
`define EIP_LIVE_MASK      8'hBF

`endif

// >>> hdl/eip_pkg.sv
package eip_pkg;

  // nesting state of the interrupt sequencer, one-hot
  typedef enum logic [3:0] {
    eip_st_idle = 4'b0001,
    eip_st_low  = 4'b0010,
    eip_st_high = 4'b0100,
    eip_st_nest = 4'b1000
  } eip_nest_t;

  typedef logic [7:0] eip_byte_t;
  typedef logic [2:0] eip_idx_t;

endpackage : eip_pkg

// >>> hdl/eip_arb_if.sv
`timescale 1ns/1ps
`default_nettype none

// carries masked requests and levels to the arbiter and its choice back
interface eip_arb_if;
  logic [7:0] pend;
  logic [7:0] lvl;
  logic       allow_high;
  logic       allow_low;
  logic       req;
  logic       high;
  logic [2:0] idx;

  modport bank (output pend, output lvl, output allow_high, output allow_low,
                input req, input high, input idx);
  modport arb  (input pend, input lvl, input allow_high, input allow_low,
                output req, output high, output idx);
endinterface : eip_arb_if

`default_nettype wire

// >>> hdl/eip_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
`include "eip_regs.svh"

module eip_arbiter
  import eip_pkg::*;
(
  // request and level vectors from the bank
  eip_arb_if.arb ai
);

  logic [`EIP_NSRC-1:0] hi_cand;
  logic [`EIP_NSRC-1:0] lo_cand;

  // split every live source into a high or a low candidate
  genvar g;
  generate
    for (g = 0; g < `EIP_NSRC; g++) begin : g_split
      assign hi_cand[g] = ai.pend[g] & ai.lvl[g];
      assign lo_cand[g] = ai.pend[g] & ~ai.lvl[g];
    end
  endgenerate

  // high level wins over low; inside a level the lowest bit wins
  always_comb begin
    ai.req  = 1'b0;
    ai.high = 1'b0;
    ai.idx  = `EIP_IDX_NONE;
    if (ai.allow_high && (|hi_cand)) begin
      ai.req  = 1'b1;
      ai.high = 1'b1;
      for (int i = `EIP_NSRC - 1; i >= 0; i--) begin
        if (hi_cand[i]) begin
          ai.idx = eip_idx_t'(i);
        end
      end
    end else if (ai.allow_low && (|lo_cand)) begin
      ai.req = 1'b1;
      for (int i = `EIP_NSRC - 1; i >= 0; i--) begin
        if (lo_cand[i]) begin
          ai.idx = eip_idx_t'(i);
        end
      end
    end
  end

endmodule : eip_arbiter

`default_nettype wire

// >>> bench/eip_bank_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module eip_bank_assertions (
  // clock and reset
  input wire logic       ref_clk_i,
  input wire logic       reset_n_i,
  // register bus
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_page_i,
  input wire logic       sfr_wr_i,
  input wire logic       sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       sfr_hit_o,
  // sequencer side
  input wire logic       irq_ack_i,
  input wire logic       irq_req_o,
  input wire logic       irq_high_o,
  input wire logic [2:0] irq_idx_o,
  input wire logic [7:0] level_select_o,
  input wire logic       low_active_o,
  input wire logic       high_active_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_wr_take; sfr_wr_i && sfr_hit_o |=> level_select_o == ($past(sfr_wdata_i) & 8'hBF); endproperty
  a_wr_take: assert property (p_wr_take) else $error("level byte not loaded");
  property p_hit; sfr_hit_o == (sfr_addr_i == 8'hCE && sfr_page_i == 8'h0F); endproperty
  a_hit: assert property (p_hit) else $error("address decode wrong");
  property p_miss_rd; sfr_rd_i && !sfr_hit_o |=> sfr_rdata_o == 8'h00; endproperty
  a_miss_rd: assert property (p_miss_rd) else $error("foreign read not zero");
  property p_no_wr; !(sfr_wr_i && sfr_hit_o) |=> $stable(level_select_o); endproperty
  a_no_wr: assert property (p_no_wr) else $error("level byte moved");
  property p_rd_data; sfr_rd_i && sfr_hit_o |=> (sfr_rdata_o & 8'hBF) == $past(level_select_o); endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data wrong");
  // levels must be settled a cycle so the registered offer can see them
  property p_high_pri; irq_req_o && $stable(level_select_o) |-> irq_high_o == level_select_o[irq_idx_o]; endproperty
  a_high_pri: assert property (p_high_pri) else $error("offer level wrong");
  property p_no_low; low_active_o || high_active_o |-> !(irq_req_o && !irq_high_o); endproperty
  a_no_low: assert property (p_no_low) else $error("low offered while busy");
  property p_ack_clear; irq_ack_i && irq_req_o |=> !irq_req_o; endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("offer kept after take");
endmodule : eip_bank_assertions

bind eip_bank eip_bank_assertions u_chk (.ref_clk_i, .reset_n_i, .sfr_addr_i, .sfr_page_i, .sfr_wr_i,
  .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .sfr_hit_o, .irq_ack_i, .irq_req_o, .irq_high_o, .irq_idx_o,
  .level_select_o, .low_active_o, .high_active_o);

`default_nettype wire

// >>> bench/eip_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module eip_core_model #(
  parameter int ACK_DLY = 2
) (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic reset_n_i,
  // offer and take
  input  wire logic irq_req_i,
  input  wire logic ack_en_i,
  output logic      irq_ack_o
);
  logic [3:0] wait_ff;

  // a slow core lets the offer stand a few cycles before taking it
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i || !irq_req_i || irq_ack_o)
      wait_ff <= 4'h0;
    else
      wait_ff <= wait_ff + 4'h1;
  end

  // one-cycle take, never without a standing offer
  always_ff @(posedge ref_clk_i) begin
    irq_ack_o <= reset_n_i && ack_en_i && irq_req_i && !irq_ack_o && (wait_ff >= ACK_DLY[3:0]);
  end
endmodule : eip_core_model

`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic       ref_clk_i, reset_n_i, sfr_wr_i, sfr_rd_i, global_enable_i, irq_ack_i, irq_return_i;
  logic       ack_en, sfr_hit_o, irq_req_o, irq_high_o, low_active_o, high_active_o;
  logic [7:0] sfr_addr_i, sfr_page_i, sfr_wdata_i, src_flag_i, src_enable_i, sfr_rdata_o, level_select_o;
  logic [2:0] irq_idx_o;
  int         err_total = 0, n_tests = 0, cyc = 0;
  int         bits[7] = '{0, 1, 2, 3, 4, 5, 7};

  eip_bank dut (.ref_clk_i, .reset_n_i, .sfr_addr_i, .sfr_page_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i,
    .sfr_rdata_o, .sfr_hit_o, .src_flag_i, .src_enable_i, .global_enable_i, .irq_ack_i, .irq_return_i,
    .irq_req_o, .irq_high_o, .irq_idx_o, .level_select_o, .low_active_o, .high_active_o);
  eip_core_model #(.ACK_DLY(2)) core (.ref_clk_i, .reset_n_i, .irq_req_i(irq_req_o), .ack_en_i(ack_en),
    .irq_ack_o(irq_ack_i));

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
    @(posedge ref_clk_i);
    sfr_addr_i <= a;
    sfr_page_i <= p;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    sfr_wr_i <= 1'b0;
    #1;
  endtask : wr

  // read data lands on the edge that takes the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] p, input logic [7:0] exp);
    @(posedge ref_clk_i);
    sfr_addr_i <= a;
    sfr_page_i <= p;
    sfr_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    sfr_rd_i <= 1'b0;
    #1 chk("rdata", exp, sfr_rdata_o);
  endtask : rdc

  task automatic ret_pulse();
    @(posedge ref_clk_i);
    irq_return_i <= 1'b1;
    @(posedge ref_clk_i);
    irq_return_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask : ret_pulse

  task automatic wrap_up();
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  // hang guard, the whole run needs under a hundred cycles
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      wrap_up();
    end
  end

  initial begin
    {reset_n_i, sfr_wr_i, sfr_rd_i, global_enable_i, irq_return_i, ack_en} = '0;
    {sfr_addr_i, sfr_page_i, sfr_wdata_i, src_flag_i, src_enable_i} = '0;
    repeat (12) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    rdc(8'hCE, 8'h0F, 8'h00);
    @(posedge ref_clk_i);
    src_flag_i <= 8'hBF;
    src_enable_i <= 8'hBF;
    global_enable_i <= 1'b1;
    // all sources pending, so only the one high source can win the offer
    foreach (bits[k]) begin
      wr(8'hCE, 8'h0F, 8'h01 << bits[k]);
      chk("level", 8'h01 << bits[k], level_select_o);
      rdc(8'hCE, 8'h0F, 8'h01 << bits[k]);
      chk("hit", 8'h01, {7'h0, sfr_hit_o});
      chk("high", 8'h01, {7'h0, irq_high_o});
      chk("idx", 8'(bits[k]), {5'h0, irq_idx_o});
    end
    wr(8'hCE, 8'h0E, 8'h3F);
    wr(8'hCD, 8'h0F, 8'h3F);
    rdc(8'hCE, 8'h0F, 8'h80);
    rdc(8'hCE, 8'h0E, 8'h00);
    chk("hit", 8'h00, {7'h0, sfr_hit_o});
    // low handler runs, then a high source preempts it
    wr(8'hCE, 8'h0F, 8'h01);
    @(posedge ref_clk_i);
    src_flag_i <= 8'h80;
    ack_en <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    #1 chk("low_act", 8'h01, {7'h0, low_active_o});
    chk("req", 8'h00, {7'h0, irq_req_o});
    @(posedge ref_clk_i);
    src_flag_i <= 8'h81;
    repeat (8) @(posedge ref_clk_i);
    #1 chk("high_act", 8'h01, {7'h0, high_active_o});
    chk("req", 8'h00, {7'h0, irq_req_o});
    src_flag_i <= 8'h00;
    ret_pulse();
    chk("unwind", 8'h02, {6'h0, low_active_o, high_active_o});
    ret_pulse();
    chk("idle", 8'h00, {6'h0, low_active_o, high_active_o});
    // global enable off hides a pending high source; on again it is offered
    ack_en <= 1'b0;
    global_enable_i <= 1'b0;
    src_flag_i <= 8'h01;
    repeat (3) @(posedge ref_clk_i);
    #1 chk("masked", 8'h00, {7'h0, irq_req_o});
    global_enable_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1 chk("offer", 8'h03, {6'h0, irq_req_o, irq_high_o});
    chk("offer_idx", 8'h00, {5'h0, irq_idx_o});
    wrap_up();
  end
endmodule : tb_top

`default_nettype wire
